// File: src/dcf_freq_counter.v
// Debug clock frequency counter top level
// Contract
// - Four probe inputs, selected per request.
// - Request starts one 1 ms gated measurement.
// - No edges in gate reports invalid.
// - Accurate between 2 kHz and 333.33 MHz; with 10 MHz sampling the code counts only below 5 MHz.
`timescale 1ns/1ps
`include "dcf_defs.vh"
module dcf_freq_counter #(
    parameter GATE_CYCLES = `DCF_GATE_CYCLES,
    parameter HZ_SCALE = `DCF_HZ_SCALE
) (
    mclk,
    nrst,
    clock_probe_inputs,
    meas_req,
    meas_sel,
    meas_busy,
    meas_done,
    meas_freq_hz,
    meas_valid
);
    input wire mclk;
    input wire nrst;
    input wire [`DCF_NUM_PROBES-1:0] clock_probe_inputs;
    input wire meas_req;
    input wire [`DCF_SEL_W-1:0] meas_sel;
    output wire meas_busy;
    output wire meas_done;
    output wire [`DCF_FREQ_W-1:0] meas_freq_hz;
    output wire meas_valid;

    localparam ST_IDLE = 3'b001;
    localparam ST_GATE = 3'b010;
    localparam ST_DONE = 3'b100;

    // ==========================================================
    // Probe synchronisers
    // ==========================================================
    wire [`DCF_NUM_PROBES-1:0] rise;
    genvar gi;
    generate
        for (gi = 0; gi < `DCF_NUM_PROBES; gi = gi + 1) begin : g_sync
            dcf_edge_sync u_sync (
                .mclk(mclk),
                .nrst(nrst),
                .async_in(clock_probe_inputs[gi]),
                .rise_pulse(rise[gi])
            );
        end
    endgenerate

    // ==========================================================
    // Measurement control
    // ==========================================================
    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg [`DCF_SEL_W-1:0] sel_reg;
    reg [31:0] gate_reg;
    reg [`DCF_CNT_W-1:0] edge_reg;
    reg [`DCF_FREQ_W-1:0] freq_reg;
    reg valid_reg;
    reg done_reg;

    wire gate_end = (gate_reg == GATE_CYCLES - 1);
    wire sel_rise = rise[sel_reg];

    function [`DCF_FREQ_W-1:0] to_hz;
        input [`DCF_CNT_W-1:0] cnt;
        reg [63:0] prod;
        begin
            prod = {44'h0, cnt} * HZ_SCALE;
            to_hz = prod[`DCF_FREQ_W-1:0];
        end
    endfunction

    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (meas_req) begin
                    state_next = ST_GATE;
                end
            end
            ST_GATE: begin
                if (gate_end) begin
                    state_next = ST_DONE;
                end
            end
            ST_DONE: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    wire [`DCF_CNT_W-1:0] final_cnt = edge_reg + {{(`DCF_CNT_W-1){1'b0}}, sel_rise};

    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= ST_IDLE;
            sel_reg <= {`DCF_SEL_W{1'b0}};
            gate_reg <= 32'h0;
            edge_reg <= {`DCF_CNT_W{1'b0}};
            freq_reg <= {`DCF_FREQ_W{1'b0}};
            valid_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            done_reg <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (meas_req) begin
                        sel_reg <= meas_sel;
                        gate_reg <= 32'h0;
                        edge_reg <= {`DCF_CNT_W{1'b0}};
                    end
                end
                ST_GATE: begin
                    gate_reg <= gate_reg + 32'h1;
                    edge_reg <= final_cnt;
                    if (gate_end) begin
                        freq_reg <= to_hz(final_cnt);
                        // Inside the 2 kHz..333.33 MHz span on 10 MHz sampling only below Nyquist counts
                        valid_reg <= (final_cnt != {`DCF_CNT_W{1'b0}});
                        done_reg <= 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    assign meas_busy = (state_reg != ST_IDLE);
    assign meas_done = done_reg;
    assign meas_freq_hz = freq_reg;
    assign meas_valid = valid_reg;
endmodule // dcf_freq_counter

// File: src/dcf_defs.vh
// Constants for the debug clock frequency counter
`ifndef DCF_DEFS_VH
`define DCF_DEFS_VH
`define DCF_MCLK_HZ 10000000
`define DCF_GATE_MS 1
`define DCF_GATE_CYCLES ((`DCF_MCLK_HZ / 1000) * `DCF_GATE_MS)
`define DCF_NUM_PROBES 4
`define DCF_SEL_W 2
`define DCF_CNT_W 20
`define DCF_FREQ_W 32
`define DCF_HZ_SCALE 1000
`define DCF_MIN_HZ 2000
`define DCF_MAX_HZ 333330000
`endif

// File: src/dcf_edge_sync.v
// Three-stage synchroniser with rising edge detection
`timescale 1ns/1ps
module dcf_edge_sync (
    mclk,
    nrst,
    async_in,
    rise_pulse
);
    input wire mclk;
    input wire nrst;
    input wire async_in;
    output wire rise_pulse;
    reg s1_reg;
    reg s2_reg;
    reg s3_reg;
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
        end else begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end
    // Edge counts when the second stage shows the new high level and the third stage still holds low
    assign rise_pulse = s2_reg & ~s3_reg;
endmodule // dcf_edge_sync

// File: test/dcf_probe_src.sv
// Probe clock source for the counter
`timescale 1ns/1ps
module dcf_probe_src (
    output logic [3:0] probe
);
    // Probe 3 stays still as a dead clock
    initial probe = 4'h0;
    always #500 probe[0] = ~probe[0];
    always #1000 probe[1] = ~probe[1];
    always #250 probe[2] = ~probe[2];
endmodule // dcf_probe_src

// File: test/dcf_freq_counter_chk.sv
// Port checker for the counter
`timescale 1ns/1ps
module dcf_freq_counter_chk #(parameter int GATE_CYCLES = 10000, parameter int HZ_SCALE = 1000) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic meas_req,
    input wire logic meas_busy,
    input wire logic meas_done,
    input wire logic [31:0] meas_freq_hz,
    input wire logic meas_valid
);
    localparam int DONE_DLY = GATE_CYCLES + 1;
    int since_req;
    // Cycles since the taken request, zero when idle
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            since_req <= 0;
        end else if (meas_done) begin
            since_req <= 0;
        end else if (meas_req && !meas_busy && since_req == 0) begin
            since_req <= 1;
        end else if (since_req != 0) begin
            since_req <= since_req + 1;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    a_req_sets_busy: assert property (meas_req && !meas_busy |=> meas_busy) else $error("no busy");
    a_gate_length: assert property (since_req != 0 |-> meas_done == (since_req == DONE_DLY)) else $error("late done");
    a_done_then_idle: assert property (meas_done |=> !meas_busy && !meas_done) else $error("no idle");
    a_valid_edges: assert property (meas_done |-> meas_valid == (meas_freq_hz != 0)) else $error("bad valid");
    a_scaled_count: assert property (meas_done |-> meas_freq_hz % HZ_SCALE == 0) else $error("bad scale");
    a_result_holds: assert property (!meas_done |-> $stable(meas_freq_hz)) else $error("result moved");
endmodule // dcf_freq_counter_chk
bind dcf_freq_counter dcf_freq_counter_chk #(.GATE_CYCLES(GATE_CYCLES), .HZ_SCALE(HZ_SCALE)) u_chk (
    .mclk(mclk), .nrst(nrst), .meas_req(meas_req), .meas_busy(meas_busy),
    .meas_done(meas_done), .meas_freq_hz(meas_freq_hz), .meas_valid(meas_valid));

// File: test/testbench.sv
// Self-checking bench for the counter
`timescale 1ns/1ps
module testbench;
    logic mclk = 0, nrst = 0, meas_req = 0;
    logic [1:0] meas_sel = 2'h0;
    wire [3:0] probes;
    wire meas_busy, meas_done, meas_valid;
    wire [31:0] meas_freq_hz;
    int miscompares = 0, total_checks = 0, cycles = 0;
    always #50 mclk = ~mclk;
    dcf_probe_src u_dcf_probe_src (.probe(probes));
    dcf_freq_counter #(.GATE_CYCLES(100), .HZ_SCALE(100000)) u_dcf_freq_counter (.mclk(mclk), .nrst(nrst),
        .clock_probe_inputs(probes), .meas_req(meas_req), .meas_sel(meas_sel), .meas_busy(meas_busy),
        .meas_done(meas_done), .meas_freq_hz(meas_freq_hz), .meas_valid(meas_valid));
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task wrap_up;
        if (miscompares == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 1000) begin
            miscompares++;
            wrap_up;
        end
    end
    // Second request while busy names another probe and must be ignored
    task measure(input logic [1:0] sel, input int edges);
        int n;
        @(posedge mclk);
        meas_req <= 1;
        meas_sel <= sel;
        @(posedge mclk);
        meas_sel <= ~sel;
        @(posedge mclk);
        meas_req <= 0;
        n = 0;
        while (meas_done !== 1'b1 && n < 200) begin
            @(negedge mclk);
            n++;
        end
        check("done", meas_done, 1);
        check("valid", meas_valid, edges > 0);
        check("freq", meas_freq_hz + 100000 >= edges * 100000 && meas_freq_hz <= edges * 100000 + 100000, 1);
        @(negedge mclk);
        check("busy", meas_busy, 0);
    endtask
    initial begin
        repeat (6) @(posedge mclk);
        nrst <= 1;
        measure(2'h0, 10);
        measure(2'h1, 5);
        measure(2'h2, 20);
        measure(2'h3, 0);
        wrap_up;
    end
endmodule // testbench
